/* mma_pkg.sv */
// What this block does
// - Management clock may stop while bus idle
// - Data bits sampled on management clock rising edge
// - Bus address strapped at reset; answer only it
// - Direct frame reaches 32 registers of 16 bits
// - Frame starts with zero then one
// - Read: nobody drives line in first turnaround bit
// - Read: device drives zero, then 16 bits
// - Registers 0-31 reachable directly; all but 13 and 14 also indirectly
// - Control and address/data registers direct only
// - Only three target device codes accepted
// - Control bits 15:14 select address or data
// - Function 00: access the extended address pointer
// - Function 01: access pointed register, no increment
package mma_pkg;

	// ==========================================================
	// Register map and fields
	localparam logic [4:0] ACCESS_CONTROL_IDX = 5'h0D;
	localparam logic [4:0] ADDRESS_DATA_IDX = 5'h0E;
	localparam int unsigned CTRL_FN_HI = 15;
	localparam int unsigned CTRL_FN_LO = 14;
	localparam int unsigned CTRL_CODE_HI = 4;
	localparam int unsigned CTRL_CODE_LO = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [1:0] FN_ADDRESS = 2'h0;
	localparam logic [1:0] FN_DATA = 2'h1;
	localparam logic [4:0] CODE_GENERAL = 5'h1F;
	localparam logic [4:0] CODE_EEE_A = 5'h03;
	localparam logic [4:0] CODE_EEE_B = 5'h07;
	localparam logic [1:0] SLOT_GENERAL = 2'h0;
	localparam logic [1:0] SLOT_EEE_A = 2'h1;
	localparam logic [1:0] SLOT_EEE_B = 2'h2;
	// Extended words kept per device code, indexed by low pointer bits
	localparam int unsigned EXT_AW = 4;
	localparam int unsigned STD_AW = 5;

	// ==========================================================
	// Frame layout
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] CNT_OP_LAST = 5'h01;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h04;
	localparam logic [4:0] CNT_TA_LAST = 5'h01;
	localparam logic [4:0] CNT_DATA_LAST = 5'h0F;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_START = 7'b0000010,
		ST_OP = 7'b0000100,
		ST_PHY = 7'b0001000,
		ST_REG = 7'b0010000,
		ST_TA = 7'b0100000,
		ST_DATA = 7'b1000000
	} mma_state_t;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] regad;
	} mma_hdr_t;

endpackage

/* mma_mdio_slave.sv */
`timescale 1ns/1ps
module mma_mdio_slave (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Management link
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	// Address straps
	input wire logic [2:0] phy_addr_strap_i
);

	// ==========================================================
	// Helpers
	function automatic logic code_ok(input logic [4:0] code);
		return (code == mma_pkg::CODE_GENERAL) || (code == mma_pkg::CODE_EEE_A) ||
			(code == mma_pkg::CODE_EEE_B);
	endfunction

	function automatic logic [1:0] code_slot(input logic [4:0] code);
		if (code == mma_pkg::CODE_EEE_A) begin
			return mma_pkg::SLOT_EEE_A;
		end else if (code == mma_pkg::CODE_EEE_B) begin
			return mma_pkg::SLOT_EEE_B;
		end
		return mma_pkg::SLOT_GENERAL;
	endfunction

	// ==========================================================
	// Synchronisers
	logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
	logic mdio_s1_q, mdio_s2_q;
	logic [2:0] strap_s1_q, strap_s2_q;
	logic rise;
	logic bit_in;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mdc_s1_q <= 1'b0;
			mdc_s2_q <= 1'b0;
			mdc_s3_q <= 1'b0;
			mdio_s1_q <= 1'b1;
			mdio_s2_q <= 1'b1;
			strap_s1_q <= 3'h0;
			strap_s2_q <= 3'h0;
		end else begin
			mdc_s1_q <= mdc_i;
			mdc_s2_q <= mdc_s1_q;
			mdc_s3_q <= mdc_s2_q;
			mdio_s1_q <= mdio_i;
			mdio_s2_q <= mdio_s1_q;
			strap_s1_q <= phy_addr_strap_i;
			strap_s2_q <= strap_s1_q;
		end
	end

	// Only rising edges advance the frame, so a stopped clock simply parks it
	assign rise = mdc_s2_q & ~mdc_s3_q;
	assign bit_in = mdio_s2_q;

	// ==========================================================
	// Strap capture after reset release
	logic [1:0] strap_cnt_q;
	logic [2:0] strap_q;
	logic strap_vld_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			strap_cnt_q <= 2'h0;
			strap_q <= 3'h0;
			strap_vld_q <= 1'b0;
		end else if (!strap_vld_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == mma_pkg::STRAP_SETTLE) begin
				strap_q <= strap_s2_q;
				strap_vld_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Frame receiver
	mma_pkg::mma_state_t state_q;
	mma_pkg::mma_hdr_t hdr_q;
	logic [4:0] cnt_q;
	logic [15:0] wdata_q;
	logic [15:0] wfull;
	logic addr_hit;
	logic rd_hit;
	logic commit;

	assign addr_hit = strap_vld_q && (hdr_q.phy == {2'h0, strap_q});
	assign rd_hit = addr_hit && (hdr_q.op == mma_pkg::OP_READ);
	assign wfull = {wdata_q[14:0], bit_in};
	assign commit = rise && (state_q == mma_pkg::ST_DATA) && (cnt_q == mma_pkg::CNT_DATA_LAST) &&
		addr_hit && (hdr_q.op == mma_pkg::OP_WRITE);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= mma_pkg::ST_IDLE;
			cnt_q <= mma_pkg::CNT_ZERO;
			hdr_q <= '0;
			wdata_q <= mma_pkg::WORD_RESET;
		end else if (rise) begin
			unique case (state_q)
				mma_pkg::ST_IDLE: begin
					if (!bit_in) begin
						state_q <= mma_pkg::ST_START;
					end
				end
				mma_pkg::ST_START: begin
					if (bit_in) begin
						state_q <= mma_pkg::ST_OP;
						cnt_q <= mma_pkg::CNT_ZERO;
					end
				end
				mma_pkg::ST_OP: begin
					hdr_q.op <= {hdr_q.op[0], bit_in};
					if (cnt_q == mma_pkg::CNT_OP_LAST) begin
						state_q <= mma_pkg::ST_PHY;
						cnt_q <= mma_pkg::CNT_ZERO;
					end else begin
						cnt_q <= cnt_q + mma_pkg::CNT_ONE;
					end
				end
				mma_pkg::ST_PHY: begin
					hdr_q.phy <= {hdr_q.phy[3:0], bit_in};
					if (cnt_q == mma_pkg::CNT_ADDR_LAST) begin
						state_q <= mma_pkg::ST_REG;
						cnt_q <= mma_pkg::CNT_ZERO;
					end else begin
						cnt_q <= cnt_q + mma_pkg::CNT_ONE;
					end
				end
				mma_pkg::ST_REG: begin
					hdr_q.regad <= {hdr_q.regad[3:0], bit_in};
					if (cnt_q == mma_pkg::CNT_ADDR_LAST) begin
						state_q <= mma_pkg::ST_TA;
						cnt_q <= mma_pkg::CNT_ZERO;
					end else begin
						cnt_q <= cnt_q + mma_pkg::CNT_ONE;
					end
				end
				mma_pkg::ST_TA: begin
					if (cnt_q == mma_pkg::CNT_TA_LAST) begin
						state_q <= mma_pkg::ST_DATA;
						cnt_q <= mma_pkg::CNT_ZERO;
					end else begin
						cnt_q <= cnt_q + mma_pkg::CNT_ONE;
					end
				end
				mma_pkg::ST_DATA: begin
					wdata_q <= wfull;
					if (cnt_q == mma_pkg::CNT_DATA_LAST) begin
						state_q <= mma_pkg::ST_IDLE;
						cnt_q <= mma_pkg::CNT_ZERO;
					end else begin
						cnt_q <= cnt_q + mma_pkg::CNT_ONE;
					end
				end
				default: begin
					state_q <= mma_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Register target decode, shared by reads and writes
	logic [15:0] ctrl_q;
	logic [15:0] ptr_q;
	logic [15:0] direct_q [32];
	logic [15:0] ext_q [64];
	logic [1:0] fn;
	logic [4:0] code;
	logic sel_ctrl, sel_ptr, sel_dir, sel_ext;
	logic [4:0] dir_idx;
	logic [5:0] ext_idx;
	logic [15:0] rd_word;

	assign fn = ctrl_q[mma_pkg::CTRL_FN_HI:mma_pkg::CTRL_FN_LO];
	assign code = ctrl_q[mma_pkg::CTRL_CODE_HI:mma_pkg::CTRL_CODE_LO];

	always_comb begin
		sel_ctrl = 1'b0;
		sel_ptr = 1'b0;
		sel_dir = 1'b0;
		sel_ext = 1'b0;
		dir_idx = hdr_q.regad;
		ext_idx = {code_slot(code), ptr_q[mma_pkg::EXT_AW-1:0]};
		if (hdr_q.regad == mma_pkg::ACCESS_CONTROL_IDX) begin
			sel_ctrl = 1'b1;
		end else if (hdr_q.regad != mma_pkg::ADDRESS_DATA_IDX) begin
			sel_dir = 1'b1;
		end else if (code_ok(code)) begin
			if (fn == mma_pkg::FN_ADDRESS) begin
				sel_ptr = 1'b1;
			end else if (fn == mma_pkg::FN_DATA) begin
				if (ptr_q[15:mma_pkg::STD_AW] != '0) begin
					sel_ext = 1'b1;
				end else if (ptr_q[mma_pkg::STD_AW-1:0] != mma_pkg::ACCESS_CONTROL_IDX &&
					ptr_q[mma_pkg::STD_AW-1:0] != mma_pkg::ADDRESS_DATA_IDX) begin
					sel_dir = 1'b1;
					dir_idx = ptr_q[mma_pkg::STD_AW-1:0];
				end
			end
		end
	end

	always_comb begin
		rd_word = mma_pkg::WORD_RESET;
		if (sel_ctrl) begin
			rd_word = ctrl_q;
		end else if (sel_ptr) begin
			rd_word = ptr_q;
		end else if (sel_dir) begin
			rd_word = direct_q[dir_idx];
		end else if (sel_ext) begin
			rd_word = ext_q[ext_idx];
		end
	end

	// ==========================================================
	// Register storage
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= mma_pkg::CTRL_RESET;
		end else if (commit && sel_ctrl) begin
			ctrl_q <= wfull;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_q <= mma_pkg::PTR_RESET;
		end else if (commit && sel_ptr) begin
			ptr_q <= wfull;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++) begin
				direct_q[i] <= mma_pkg::WORD_RESET;
			end
		end else if (commit && sel_dir) begin
			direct_q[dir_idx] <= wfull;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 64; i++) begin
				ext_q[i] <= mma_pkg::WORD_RESET;
			end
		end else if (commit && sel_ext) begin
			ext_q[ext_idx] <= wfull;
		end
	end

	// ==========================================================
	// Read driver: released in the first turnaround bit, zero in the second
	logic [15:0] shift_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mdio_o <= 1'b1;
			mdio_oe_o <= 1'b0;
			shift_q <= mma_pkg::WORD_RESET;
		end else if (rise) begin
			if (state_q == mma_pkg::ST_TA && cnt_q == mma_pkg::CNT_ZERO && rd_hit) begin
				mdio_oe_o <= 1'b1;
				mdio_o <= 1'b0;
				shift_q <= rd_word;
			end else if (mdio_oe_o && state_q == mma_pkg::ST_DATA &&
				cnt_q == mma_pkg::CNT_DATA_LAST) begin
				mdio_oe_o <= 1'b0;
				mdio_o <= 1'b1;
			end else if (mdio_oe_o) begin
				mdio_o <= shift_q[15];
				shift_q <= {shift_q[14:0], 1'b0};
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_ta_read;
		rise && state_q == mma_pkg::ST_TA && cnt_q == mma_pkg::CNT_ZERO && rd_hit;
	endsequence

	sequence s_drive_zero;
		mdio_oe_o && !mdio_o;
	endsequence

	a_turn_zero: assert property (s_ta_read |=> s_drive_zero)
		else $error("second turnaround bit not driven low");
	a_ta1_released: assert property (state_q == mma_pkg::ST_TA && cnt_q == mma_pkg::CNT_ZERO
		|-> !mdio_oe_o)
		else $error("line driven in first turnaround bit");
	a_read_release: assert property (rise && state_q == mma_pkg::ST_DATA &&
		cnt_q == mma_pkg::CNT_DATA_LAST |=> !mdio_oe_o)
		else $error("line not released after last data bit");
	a_miss_quiet: assert property (!rd_hit |-> !mdio_oe_o)
		else $error("line driven for another address");
	a_start_seen: assert property ($rose(state_q == mma_pkg::ST_OP) |->
		$past(state_q == mma_pkg::ST_START) && $past(bit_in))
		else $error("frame entered without start pattern");
	a_ptr_write: assert property (commit && sel_ptr |=> ptr_q == $past(wfull))
		else $error("pointer not updated");
	a_ptr_stay: assert property (commit && !sel_ptr |=> $stable(ptr_q))
		else $error("pointer moved on data access");
	a_code_gate: assert property (hdr_q.regad == mma_pkg::ADDRESS_DATA_IDX && !code_ok(code)
		|-> !(sel_ptr || sel_dir || sel_ext))
		else $error("access under invalid device code");
	a_shield_ctrl: assert property (sel_dir |-> dir_idx != mma_pkg::ACCESS_CONTROL_IDX &&
		dir_idx != mma_pkg::ADDRESS_DATA_IDX)
		else $error("indirect path reached control registers");
	a_edge_only: assert property (!rise |=> $stable(state_q))
		else $error("frame advanced without clock edge");
	a_strap_hold: assert property (strap_vld_q |=> $stable(strap_q) && strap_vld_q)
		else $error("strapped address changed");

endmodule // mma_mdio_slave

/* mma_sta_model.sv */
`timescale 1ns/1ps
module mma_sta_model (
	// Clock
	input wire logic clk_i,
	// Management link
	input wire logic mdio_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o
);
	// Extra low-phase cycles per bit, for a slow controller
	int pause = 0;

	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end

	// ==========================================================
	// One bit time: 7 clk of 50 ns, so MDC runs at about 2.86 MHz
	task automatic bit_t(input logic oe, input logic v, output logic s);
		@(negedge clk_i);
		mdc_o = 1'b0;
		mdio_oe_o = oe;
		// Released: no stale level left on our side of the pull-up
		mdio_o = oe ? v : ~mdio_o;
		repeat (3 + pause) @(negedge clk_i);
		s = mdio_i;
		mdc_o = 1'b1;
		repeat (3) @(negedge clk_i);
	endtask

	// ==========================================================
	// Whole frame; MDC stands low between frames
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] ta);
		logic [15:0] h;
		logic s;
		logic w;
		h = {2'h3, 2'h1, op, phy, ra};
		w = (op != 2'h2);
		for (int i = 15; i >= 0; i--)
			bit_t(1'b1, h[i], s);
		bit_t(w, 1'b1, ta[1]);
		bit_t(w, 1'b0, ta[0]);
		for (int i = 15; i >= 0; i--) begin
			bit_t(w, wd[i], s);
			rd[i] = s;
		end
		@(negedge clk_i);
		mdc_o = 1'b0;
		mdio_oe_o = 1'b0;
	endtask
endmodule // mma_sta_model

/* tb_mma_mdio_slave.sv */
`timescale 1ns/1ps
module tb_mma_mdio_slave;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [4:0] ME = {2'h0, STRAP};
	localparam logic [4:0] CR = mma_pkg::ACCESS_CONTROL_IDX;
	localparam logic [4:0] AD = mma_pkg::ADDRESS_DATA_IDX;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] strap = STRAP;
	logic [4:0] me = ME;
	logic mdc;
	logic sta_o;
	logic sta_oe;
	logic dev_o;
	logic dev_oe;
	logic mdio_w;
	logic watch = 1'b0;
	logic oe_seen = 1'b0;
	logic [15:0] rd;
	logic [1:0] ta;
	logic [4:0] codes [3] = '{5'h1F, 5'h03, 5'h07};
	int err_total = 0;
	int checked = 0;

	always #25 clk_i = ~clk_i;
	// Pull-up: a released line reads high
	assign mdio_w = (dev_oe ? dev_o : 1'b1) & (sta_oe ? sta_o : 1'b1);

	mma_mdio_slave mma_mdio_slave_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mdc_i(mdc),
		.mdio_i(mdio_w),
		.mdio_o(dev_o),
		.mdio_oe_o(dev_oe),
		.phy_addr_strap_i(strap)
	);
	mma_sta_model mma_sta_model_i (
		.clk_i(clk_i),
		.mdio_i(mdio_w),
		.mdc_o(mdc),
		.mdio_o(sta_o),
		.mdio_oe_o(sta_oe)
	);

	always @(posedge clk_i) if (watch && dev_oe) oe_seen <= 1'b1;

	// ==========================================================
	// Access tasks
	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		mma_sta_model_i.xfer(2'h1, me, ra, d, rd, ta);
	endtask
	task automatic rc(input logic [4:0] ra, input logic [15:0] exp, input string n);
		mma_sta_model_i.xfer(2'h2, me, ra, 16'h0000, rd, ta);
		chk("ta", {14'h0000, ta}, 16'h0002);
		chk(n, rd, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial begin
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (8) @(negedge clk_i);
		rc(CR, mma_pkg::CTRL_RESET, "ctrl rst");
		rc(AD, mma_pkg::PTR_RESET, "ptr rst");
		wr(5'h02, 16'hA5C3);
		wr(5'h1F, 16'h8001);
		rc(5'h02, 16'hA5C3, "reg2");
		rc(5'h1F, 16'h8001, "reg31");
		// Strap bits alone match here; the upper address bits do not
		watch = 1'b1;
		mma_sta_model_i.xfer(2'h1, 5'h15, 5'h02, 16'hFFFF, rd, ta);
		mma_sta_model_i.xfer(2'h2, 5'h15, 5'h02, 16'h0000, rd, ta);
		watch = 1'b0;
		chk("far rd", rd, 16'hFFFF);
		chk("far oe", {15'h0000, oe_seen}, 16'h0000);
		// Straps are latched: moving the pins later must not move the address
		strap = 3'h2;
		rc(5'h02, 16'hA5C3, "reg2 kept");
		mma_sta_model_i.pause = 20;
		rc(5'h1F, 16'h8001, "slow");
		mma_sta_model_i.pause = 0;
		for (int i = 0; i < 3; i++) begin
			wr(CR, {11'h000, codes[i]});
			wr(AD, 16'h0470);
			wr(AD, 16'h0461);
			rc(AD, 16'h0461, "ptr");
			wr(CR, {2'h1, 9'h000, codes[i]});
			rc(CR, {2'h1, 9'h000, codes[i]}, "ctrl");
			wr(AD, 16'hDEAD);
			wr(AD, 16'h1000 + 16'(i));
			rc(AD, 16'h1000 + 16'(i), "ext");
			rc(AD, 16'h1000 + 16'(i), "ext again");
		end
		for (int i = 0; i < 3; i++) begin
			wr(CR, {2'h1, 9'h000, codes[i]});
			rc(AD, 16'h1000 + 16'(i), "ext sep");
		end
		wr(CR, 16'h4005);
		rc(AD, 16'h0000, "bad code");
		wr(AD, 16'h5555);
		wr(CR, 16'h801F);
		rc(AD, 16'h0000, "fn10");
		wr(CR, 16'h401F);
		rc(AD, 16'h1000, "code kept");
		wr(CR, 16'h001F);
		wr(AD, 16'h0002);
		wr(CR, 16'h401F);
		rc(AD, 16'hA5C3, "ind reg2");
		wr(AD, 16'h1234);
		rc(5'h02, 16'h1234, "dir reg2");
		wr(CR, 16'h001F);
		wr(AD, 16'h000D);
		wr(CR, 16'h401F);
		rc(AD, 16'h0000, "ind ctrl");
		wr(AD, 16'h0000);
		rc(CR, 16'h401F, "ctrl kept");
		// Reset in mid-run clears the registers and relatches the straps
		rst_i = 1'b1;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (8) @(negedge clk_i);
		me = {2'h0, strap};
		rc(CR, mma_pkg::CTRL_RESET, "ctrl rst2");
		rc(5'h02, mma_pkg::WORD_RESET, "reg2 rst");
		mma_sta_model_i.xfer(2'h2, ME, 5'h02, 16'h0000, rd, ta);
		chk("old addr", rd, 16'hFFFF);
		tally_and_finish();
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		tally_and_finish();
	end
endmodule // tb_mma_mdio_slave
